/* File: src/host_port_regs.vh */
// What this block does
// - Address latched from shared lines on falling edge of latch strobe.
// - Second bus family: strobe/mode-zero level picks auxiliary pin role.
// - Seven register-select lines choose one internal register per access in family low; family high reuses the last latched address.
// - Active-low interrupt asserted whenever any internal source requests.
// - Interrupt source and cause readable in status registers.
// - Interrupt pin only pulls low, never drives high.
// - Acknowledge acts as select: reads pop receive FIFO, writes push transmit.
// - Any active acknowledge overrides register selects, FIFO addressed.
// - Bus-family input low: separate read/write strobes; high: alternative.
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
`define ADDR_W 7
`define SRC_W 8
// Register-select codes for the status and FIFO views
`define ADDR_FIFO_A 7'h00
`define ADDR_FIFO_B 7'h40
`define ADDR_CAUSE_A 7'h20
`define ADDR_CAUSE_B 7'h60
`define ADDR_EXT_A 7'h24
`define ADDR_EXT_B 7'h64
`define CAUSE_RESET 8'h00
`define TGT_NONE 3'h0
`define TGT_FIFO_A 3'h1
`define TGT_FIFO_B 3'h2
`define TGT_CAUSE_A 3'h3
`define TGT_CAUSE_B 3'h4
`define TGT_EXT_A 3'h5
`define TGT_EXT_B 3'h6
`endif

/* File: src/irq_cause_keeper.v */
`timescale 1ns/100ps
`default_nettype none
`include "host_port_regs.vh"
module irq_cause_keeper
(
  input wire clk_in,
  input wire reset_in,
  input wire [`SRC_W-1:0] event_in,
  input wire read_ack_in,
  output reg [`SRC_W-1:0] cause_q,
  output wire pending_out
);
  reg [`SRC_W-1:0] cause_d;

  // Read shows all of cause_q, so all of it clears; a new event wins
  always @*
  begin
    cause_d = cause_q;
    if (read_ack_in)
      cause_d = {`SRC_W{1'b0}};
    cause_d = cause_d | event_in;
  end

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cause_q <= `CAUSE_RESET;
    end
    else
    begin
      cause_q <= cause_d;
    end
  end

  assign pending_out = |cause_q;
endmodule // irq_cause_keeper
`default_nettype wire

/* File: src/host_bus_port.v */
`timescale 1ns/100ps
`default_nettype none
`include "host_port_regs.vh"
module host_bus_port
(
  input wire CLK_IN,
  input wire RESET_IN,
  input wire BUS_FAMILY_SELECT_IN,
  input wire BUS_MODE_SELECT_LOW_IN,
  input wire [`ADDR_W-1:0] REGISTER_SELECT_LINES_IN,
  input wire RD_N_IN,
  input wire WR_N_IN,
  input wire CS_N_IN,
  input wire DMA_GRANT_CH_A_N_IN,
  input wire DMA_GRANT_CH_B_N_IN,
  input wire [`SRC_W-1:0] EVENT_A_IN,
  input wire [`SRC_W-1:0] EVENT_B_IN,
  input wire [`SRC_W-1:0] EXT_EVENT_A_IN,
  input wire [`SRC_W-1:0] EXT_EVENT_B_IN,
  input wire [7:0] RX_FIFO_A_IN,
  input wire [7:0] RX_FIFO_B_IN,
  output reg [`ADDR_W-1:0] LATCHED_ADDR_OUT,
  output reg [2:0] TARGET_OUT,
  output reg [7:0] READ_DATA_OUT,
  output reg READ_VALID_OUT,
  output wire RX_POP_A_OUT,
  output wire RX_POP_B_OUT,
  output wire TX_PUSH_A_OUT,
  output wire TX_PUSH_B_OUT,
  output wire REG_WRITE_OUT,
  output wire AUX_BUS_CONTROL_PIN_ROLE_OUT,
  output wire INT_N_OUT,
  output wire INT_N_OE_OUT
);
  reg ale_prev_q;
  reg [`ADDR_W-1:0] addr_q;
  reg [`ADDR_W-1:0] lines_prev_q;
  reg rd_prev_q;
  reg wr_prev_q;
  wire [`ADDR_W-1:0] eff_addr;
  wire ale_fall;
  wire rd_strobe;
  wire wr_strobe;
  wire grant_a;
  wire grant_b;
  wire reg_sel;
  wire [2:0] tgt;
  wire [`SRC_W-1:0] cause_a;
  wire [`SRC_W-1:0] cause_b;
  wire [`SRC_W-1:0] ext_a;
  wire [`SRC_W-1:0] ext_b;
  wire [3:0] pend;
  wire [`SRC_W*4-1:0] evt_bus;
  wire [3:0] ack;

  // Register map decode, also used to pick read data
  function [2:0] decode;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `ADDR_FIFO_A: decode = `TGT_FIFO_A;
        `ADDR_FIFO_B: decode = `TGT_FIFO_B;
        `ADDR_CAUSE_A: decode = `TGT_CAUSE_A;
        `ADDR_CAUSE_B: decode = `TGT_CAUSE_B;
        `ADDR_EXT_A: decode = `TGT_EXT_A;
        `ADDR_EXT_B: decode = `TGT_EXT_B;
        default: decode = `TGT_NONE;
      endcase
    end
  endfunction

  // Latch strobe shares the mode-zero pin; only meaningful in family low
  assign ale_fall = ale_prev_q & ~BUS_MODE_SELECT_LOW_IN;
  // Held-high latch strobe passes the address lines straight through
  assign eff_addr = (!BUS_FAMILY_SELECT_IN && BUS_MODE_SELECT_LOW_IN) ?
    REGISTER_SELECT_LINES_IN : addr_q;

  // Family low: separate active-low strobes. High: RD_N is R/W, WR_N is DS
  assign rd_strobe = BUS_FAMILY_SELECT_IN ? (RD_N_IN & ~WR_N_IN) :
    ~RD_N_IN;
  assign wr_strobe = BUS_FAMILY_SELECT_IN ? (~RD_N_IN & ~WR_N_IN) :
    ~WR_N_IN;
  assign AUX_BUS_CONTROL_PIN_ROLE_OUT = BUS_FAMILY_SELECT_IN &
    BUS_MODE_SELECT_LOW_IN;

  assign grant_a = ~DMA_GRANT_CH_A_N_IN;
  assign grant_b = ~DMA_GRANT_CH_B_N_IN & DMA_GRANT_CH_A_N_IN;
  assign reg_sel = ~CS_N_IN & DMA_GRANT_CH_A_N_IN & DMA_GRANT_CH_B_N_IN;
  // Grants override the selects; channel A wins if both are low
  assign tgt = grant_a ? `TGT_FIFO_A : grant_b ? `TGT_FIFO_B :
    reg_sel ? decode(eff_addr) : `TGT_NONE;

  // One-cycle pulses on strobe leading edges
  assign RX_POP_A_OUT = rd_strobe & ~rd_prev_q &
    (tgt == `TGT_FIFO_A);
  assign RX_POP_B_OUT = rd_strobe & ~rd_prev_q &
    (tgt == `TGT_FIFO_B);
  assign TX_PUSH_A_OUT = wr_strobe & ~wr_prev_q &
    (tgt == `TGT_FIFO_A);
  assign TX_PUSH_B_OUT = wr_strobe & ~wr_prev_q &
    (tgt == `TGT_FIFO_B);
  assign REG_WRITE_OUT = wr_strobe & ~wr_prev_q & reg_sel;

  assign evt_bus = {EXT_EVENT_B_IN, EXT_EVENT_A_IN, EVENT_B_IN, EVENT_A_IN};
  assign ack[0] = rd_strobe & ~rd_prev_q & (tgt == `TGT_CAUSE_A);
  assign ack[1] = rd_strobe & ~rd_prev_q & (tgt == `TGT_CAUSE_B);
  assign ack[2] = rd_strobe & ~rd_prev_q & (tgt == `TGT_EXT_A);
  assign ack[3] = rd_strobe & ~rd_prev_q & (tgt == `TGT_EXT_B);

  genvar gi;
  wire [`SRC_W*4-1:0] cause_bus;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_cause
      irq_cause_keeper u_keep
      (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .event_in(evt_bus[gi*`SRC_W +: `SRC_W]),
        .read_ack_in(ack[gi]),
        .cause_q(cause_bus[gi*`SRC_W +: `SRC_W]),
        .pending_out(pend[gi])
      );
    end
  endgenerate
  assign cause_a = cause_bus[`SRC_W-1:0];
  assign cause_b = cause_bus[2*`SRC_W-1:`SRC_W];
  assign ext_a = cause_bus[3*`SRC_W-1:2*`SRC_W];
  assign ext_b = cause_bus[4*`SRC_W-1:3*`SRC_W];

  // Open drain: output level is always low, only the enable moves
  assign INT_N_OUT = 1'b0;
  assign INT_N_OE_OUT = |pend;

  always @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      ale_prev_q <= 1'b0;
      addr_q <= {`ADDR_W{1'b0}};
      lines_prev_q <= {`ADDR_W{1'b0}};
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      LATCHED_ADDR_OUT <= {`ADDR_W{1'b0}};
      TARGET_OUT <= `TGT_NONE;
      READ_DATA_OUT <= 8'h00;
      READ_VALID_OUT <= 1'b0;
    end
    else
    begin
      ale_prev_q <= BUS_MODE_SELECT_LOW_IN & ~BUS_FAMILY_SELECT_IN;
      // Lines already carry data once the strobe is low; use last address
      lines_prev_q <= REGISTER_SELECT_LINES_IN;
      if (ale_fall && !BUS_FAMILY_SELECT_IN)
        addr_q <= lines_prev_q;
      rd_prev_q <= rd_strobe;
      wr_prev_q <= wr_strobe;
      LATCHED_ADDR_OUT <= eff_addr;
      TARGET_OUT <= tgt;
      READ_VALID_OUT <= rd_strobe & ~rd_prev_q & (tgt != `TGT_NONE);
      if (rd_strobe && !rd_prev_q)
      begin
        case (tgt)
          `TGT_FIFO_A: READ_DATA_OUT <= RX_FIFO_A_IN;
          `TGT_FIFO_B: READ_DATA_OUT <= RX_FIFO_B_IN;
          `TGT_CAUSE_A: READ_DATA_OUT <= cause_a;
          `TGT_CAUSE_B: READ_DATA_OUT <= cause_b;
          `TGT_EXT_A: READ_DATA_OUT <= ext_a;
          `TGT_EXT_B: READ_DATA_OUT <= ext_b;
          default: READ_DATA_OUT <= 8'h00;
        endcase
      end
    end
  end
endmodule // host_bus_port
`default_nettype wire

/* File: verif/host_bus_port_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_checker (
  input wire logic CLK_IN, RESET_IN, BUS_FAMILY_SELECT_IN,
  input wire logic BUS_MODE_SELECT_LOW_IN, RD_N_IN, WR_N_IN,
  input wire logic DMA_GRANT_CH_A_N_IN, DMA_GRANT_CH_B_N_IN,
  input wire logic [7:0] EVENT_A_IN, RX_FIFO_A_IN, READ_DATA_OUT,
  input wire logic [6:0] LATCHED_ADDR_OUT,
  input wire logic READ_VALID_OUT, RX_POP_A_OUT, TX_PUSH_A_OUT,
  input wire logic TX_PUSH_B_OUT, REG_WRITE_OUT, INT_N_OUT,
  input wire logic INT_N_OE_OUT, AUX_BUS_CONTROL_PIN_ROLE_OUT
);
  wire f = BUS_FAMILY_SELECT_IN;
  wire m = BUS_MODE_SELECT_LOW_IN;
  wire ga = DMA_GRANT_CH_A_N_IN;
  wire gb = DMA_GRANT_CH_B_N_IN;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_drv; !INT_N_OUT; endproperty
  a_drv: assert property (p_drv) else $error("int high");
  property p_aux; AUX_BUS_CONTROL_PIN_ROLE_OUT == (f && m); endproperty
  a_aux: assert property (p_aux) else $error("aux role");
  property p_lat; (!f && !m) [*3] |=> $stable(LATCHED_ADDR_OUT); endproperty
  a_lat: assert property (p_lat) else $error("addr moved");
  property p_pop; !f && !ga && !RD_N_IN && $past(RD_N_IN) |-> RX_POP_A_OUT;
  endproperty
  a_pop: assert property (p_pop) else $error("no pop");
  property p_psh; !f && ga && !gb && !WR_N_IN && $past(WR_N_IN)
    |-> TX_PUSH_B_OUT && !TX_PUSH_A_OUT; endproperty
  a_psh: assert property (p_psh) else $error("no push");
  property p_sel; !(ga && gb) |-> !REG_WRITE_OUT; endproperty
  a_sel: assert property (p_sel) else $error("reg write");
  property p_irq; EVENT_A_IN != 8'h00 |=> INT_N_OE_OUT; endproperty
  a_irq: assert property (p_irq) else $error("no irq");
  property p_rd; RX_POP_A_OUT |=> READ_VALID_OUT
    && READ_DATA_OUT == $past(RX_FIFO_A_IN) ##1 !READ_VALID_OUT; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  c_pop: cover property (RX_POP_A_OUT);
  c_psh: cover property (TX_PUSH_B_OUT);
  c_irq: cover property (INT_N_OE_OUT);
endmodule // host_bus_port_checker
`default_nettype wire

/* File: verif/host_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic wr_in,
  output logic rd_n_out,
  output logic wr_n_out
);
  logic [1:0] n_q;
  // Two low cycles, then idle so strobes never run back to back
  wire logic hold = go_in && n_q == 2'h0 || n_q == 2'h3;
  initial {n_q, rd_n_out, wr_n_out} = 4'h3;
  always @(posedge clk_in)
  begin
    if (go_in && n_q == 2'h0)
      n_q <= 2'h3;
    else if (n_q != 2'h0)
      n_q <= n_q - 2'h1;
    rd_n_out <= !(hold && !wr_in);
    wr_n_out <= !(hold && wr_in);
  end
endmodule // host_cpu_model
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "host_port_regs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  mismatches++; $display("unexpected %0t %h %h", $time, a, e); end end
module testbench;
  logic CLK_IN = 0, RESET_IN = 1, BUS_FAMILY_SELECT_IN = 0, go = 0, wr = 0;
  logic BUS_MODE_SELECT_LOW_IN = 1, CS_N_IN = 0, RD_N_IN, WR_N_IN;
  logic DMA_GRANT_CH_A_N_IN = 1, DMA_GRANT_CH_B_N_IN = 1;
  logic [6:0] REGISTER_SELECT_LINES_IN = 7'h00, LATCHED_ADDR_OUT;
  logic [7:0] EVENT_A_IN = 8'h00, EVENT_B_IN = 8'h00, RX_FIFO_A_IN = 8'h00;
  logic [7:0] EXT_EVENT_A_IN = 8'h00, EXT_EVENT_B_IN = 8'h00;
  logic [7:0] RX_FIFO_B_IN = 8'h3c, READ_DATA_OUT;
  logic [2:0] TARGET_OUT;
  logic READ_VALID_OUT, RX_POP_A_OUT, RX_POP_B_OUT, TX_PUSH_A_OUT;
  logic TX_PUSH_B_OUT, REG_WRITE_OUT, AUX_BUS_CONTROL_PIN_ROLE_OUT;
  logic INT_N_OUT, INT_N_OE_OUT;
  int mismatches = 0, comparisons = 0, cycles = 0, pushes = 0;
  host_bus_port u_host_bus_port (.*);
  host_cpu_model u_host_cpu_model (.clk_in(CLK_IN), .go_in(go), .wr_in(wr),
    .rd_n_out(RD_N_IN), .wr_n_out(WR_N_IN));
  initial forever #2.5 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN)
  begin
    cycles++;
    pushes += TX_PUSH_B_OUT;
    if (cycles == 3000) mismatches++;
    if (cycles == 3000) finish_test;
  end
  task tick(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask
  task acc(input logic w);
    wr <= w;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(5);
  endtask
  task finish_test;
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task t_latch;
    // 8-bit host: select lines map straight, no doubling
    REGISTER_SELECT_LINES_IN <= `ADDR_CAUSE_A;
    tick(1);
    BUS_MODE_SELECT_LOW_IN <= 1'b0;
    REGISTER_SELECT_LINES_IN <= 7'h55; // Lines reused as data after latch
    tick(3);
    `CHK(LATCHED_ADDR_OUT, `ADDR_CAUSE_A)
  endtask
  task t_cause;
    BUS_MODE_SELECT_LOW_IN <= 1'b1;
    REGISTER_SELECT_LINES_IN <= `ADDR_CAUSE_A;
    EVENT_A_IN <= 8'h81;
    tick(1);
    EVENT_A_IN <= 8'h00;
    tick(1);
    `CHK(INT_N_OE_OUT, 1'b1)
    `CHK(INT_N_OUT, 1'b0)
    acc(1'b0);
    `CHK(READ_DATA_OUT, 8'h81)
    `CHK(INT_N_OE_OUT, 1'b0)
  endtask
  task t_dma;
    DMA_GRANT_CH_A_N_IN <= 1'b0;
    REGISTER_SELECT_LINES_IN <= `ADDR_CAUSE_B;
    RX_FIFO_A_IN <= 8'ha5;
    acc(1'b0);
    `CHK(READ_DATA_OUT, 8'ha5)
    DMA_GRANT_CH_A_N_IN <= 1'b1;
    DMA_GRANT_CH_B_N_IN <= 1'b0;
    acc(1'b1);
    `CHK(pushes, 1)
    DMA_GRANT_CH_B_N_IN <= 1'b1;
  endtask
  task t_aux;
    BUS_FAMILY_SELECT_IN <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      BUS_MODE_SELECT_LOW_IN <= i[0];
      tick(1);
      `CHK(AUX_BUS_CONTROL_PIN_ROLE_OUT, i[0])
    end
  endtask
  initial
  begin
    tick(16);
    RESET_IN <= 1'b0;
    tick(2);
    t_latch;
    t_cause;
    t_dma;
    t_aux;
    finish_test;
  end
endmodule // testbench
bind host_bus_port host_bus_port_checker u_host_bus_port_checker (.*);
`default_nettype wire
